// >>> rtl/pvt_buf2.v
// Two-entry valid/ready buffer
`timescale 1ns/1ps
`default_nettype none
module pvt_buf2 #(
	parameter W = 32
) (
	input  wire         ref_clk,
	input  wire         nrst,
	input  wire [W-1:0] in_data,
	input  wire         in_valid,
	output wire         in_ready,
	output wire [W-1:0] out_data,
	output wire         out_valid,
	input  wire         out_ready
);
	reg [W-1:0] mem_ff [0:1];
	reg         wp_ff;
	reg         rp_ff;
	reg [1:0]   cnt_ff;
	reg [1:0]   nxt_cnt;
	reg         ready_ff;
	wire        push;
	wire        pop;
	// Ready comes from a flip-flop, set while not full
	assign in_ready  = ready_ff;
	assign out_valid = (cnt_ff != 2'd0);
	assign out_data  = mem_ff[rp_ff];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	always @* begin
		nxt_cnt = cnt_ff;
		if (push & ~pop)
			nxt_cnt = cnt_ff + 2'd1;
		else if (pop & ~push)
			nxt_cnt = cnt_ff - 2'd1;
	end
	always @(posedge ref_clk) begin
		if (push)
			mem_ff[wp_ff] <= in_data;
	end
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wp_ff  <= 1'b0;
			rp_ff  <= 1'b0;
			cnt_ff <= 2'd0;
			ready_ff <= 1'b1;
		end else begin
			if (push)
				wp_ff <= ~wp_ff;
			if (pop)
				rp_ff <= ~rp_ff;
			cnt_ff   <= nxt_cnt;
			ready_ff <= (nxt_cnt != 2'd2);
		end
	end
endmodule
`default_nettype wire

// >>> rtl/pvt_defs.vh
// Timing limits of the panel video stream
`ifndef PVT_DEFS_VH
`define PVT_DEFS_VH
`define PVT_V_ACTIVE      12'd2160
`define PVT_V_TOTAL_MIN   13'd2180
`define PVT_V_TOTAL_TYP   13'd2200
`define PVT_V_TOTAL_MAX   13'd4500
`define PVT_V_BLANK_MIN   13'd20
`define PVT_V_BLANK_TYP   13'd40
`define PVT_V_BLANK_MAX   13'd2340
`define PVT_H_ACTIVE      12'd1920
`define PVT_H_TOTAL_MIN   12'd2000
`define PVT_H_TOTAL_TYP   12'd2100
`define PVT_H_TOTAL_MAX   12'd3520
`define PVT_H_BLANK_MIN   12'd80
`define PVT_H_BLANK_TYP   12'd180
`define PVT_H_BLANK_MAX   12'd1600
`define PVT_PCLK_MIN_KHZ  32'd80000
`define PVT_PCLK_TYP_KHZ  32'd277000
`define PVT_PCLK_MAX_KHZ  32'd300300
`define PVT_FRATE_MIN_HZ  7'd29
`define PVT_FRATE_OPT_HZ  7'd50
`define PVT_FRATE_TYP_HZ  7'd60
`define PVT_FRATE_MAX_HZ  7'd65
`define PVT_LRATE_MIN_KHZ 8'd40
`define PVT_LRATE_TYP_KHZ 8'd132
`define PVT_LRATE_MAX_KHZ 8'd151
`define PVT_LANE_MBPS     16'd2700
`define PVT_SKEW_MAX_NS   16'd200
`define PVT_REF_MHZ       16'd25
`endif

// >>> rtl/pvt_source.v
// Video source timing generator honouring the panel timing window
`timescale 1ns/1ps
`default_nettype none
`include "pvt_defs.vh"
module pvt_source #(
	parameter PW = 30
) (
	input  wire          ref_clk,
	input  wire          nrst,
	input  wire          pwr_good,
	input  wire          video_en,
	input  wire [11:0]   cfg_h_blank,
	input  wire [12:0]   cfg_v_blank,
	input  wire [31:0]   cfg_pclk_khz,
	input  wire [PW-1:0] pix_data,
	input  wire          pix_valid,
	output wire          pix_ready,
	output reg  [PW-1:0] vid_data,
	output reg           vid_de,
	output reg           vid_hs,
	output reg           vid_vs,
	output reg           vid_sof,
	output reg           vid_oe,
	input  wire          vid_ready,
	output reg           running,
	output reg           cfg_err,
	output reg           rate_opt,
	output reg  [15:0]   lane_mbps,
	output reg  [15:0]   skew_max_ns
);
	localparam ST_OFF  = 2'd0;
	localparam ST_WAIT = 2'd1;
	localparam ST_RUN  = 2'd2;
	localparam ST_STOP = 2'd3;

	reg [1:0]  st_ff;
	reg [1:0]  nxt_st;
	reg        pg_s1_ff;
	reg        pg_s2_ff;
	reg        en_s1_ff;
	reg        en_s2_ff;
	reg [11:0] hb_ff;
	reg [12:0] vb_ff;
	reg [11:0] hcnt_ff;
	reg [12:0] vcnt_ff;
	reg        cfg_ok;
	reg [11:0] h_total;
	reg [12:0] v_total;
	reg [63:0] frate_x;
	reg [63:0] lrate_x;
	reg        frate_ok;
	reg        fopt_ok;
	reg        lrate_ok;
	reg [63:0] tot_prod;
	wire [PW-1:0] b_data;
	wire          b_valid;
	wire          b_ready;
	wire          adv;
	wire          h_act;
	wire          v_act;
	wire          line_end;
	wire          frame_end;

	pvt_buf2 #(
		.W(PW)
	) u_buf (
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.in_data  (pix_data),
		.in_valid (pix_valid),
		.in_ready (pix_ready),
		.out_data (b_data),
		.out_valid(b_valid),
		.out_ready(b_ready)
	);

	// Power-good and enable pins cross into ref_clk
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pg_s1_ff <= 1'b0;
			pg_s2_ff <= 1'b0;
			en_s1_ff <= 1'b0;
			en_s2_ff <= 1'b0;
		end else begin
			pg_s1_ff <= pwr_good;
			pg_s2_ff <= pg_s1_ff;
			en_s1_ff <= video_en;
			en_s2_ff <= en_s1_ff;
		end
	end

	// Configuration checks against the panel window
	always @* begin
		h_total  = `PVT_H_ACTIVE + cfg_h_blank;
		v_total  = {1'b0, `PVT_V_ACTIVE} + cfg_v_blank;
		tot_prod = {52'd0, h_total} * {51'd0, v_total};
		frate_x  = (tot_prod == 64'd0) ? 64'd0
			: ({32'd0, cfg_pclk_khz} * 64'd1000) / tot_prod;
		lrate_x  = (h_total == 12'd0) ? 64'd0
			: {32'd0, cfg_pclk_khz} / {52'd0, h_total};
		frate_ok = (frate_x >= {57'd0, `PVT_FRATE_MIN_HZ})
			&& (frate_x <= {57'd0, `PVT_FRATE_MAX_HZ});
		fopt_ok  = (frate_x >= {57'd0, `PVT_FRATE_OPT_HZ}) && frate_ok;
		lrate_ok = (lrate_x >= {56'd0, `PVT_LRATE_MIN_KHZ})
			&& (lrate_x <= {56'd0, `PVT_LRATE_MAX_KHZ});
		cfg_ok   = (cfg_h_blank >= `PVT_H_BLANK_MIN) && (cfg_h_blank <= `PVT_H_BLANK_MAX)
			&& (cfg_v_blank >= `PVT_V_BLANK_MIN) && (cfg_v_blank <= `PVT_V_BLANK_MAX)
			&& (h_total >= `PVT_H_TOTAL_MIN) && (h_total <= `PVT_H_TOTAL_MAX)
			&& (v_total >= `PVT_V_TOTAL_MIN) && (v_total <= `PVT_V_TOTAL_MAX)
			&& (cfg_pclk_khz >= `PVT_PCLK_MIN_KHZ)
			&& (cfg_pclk_khz <= `PVT_PCLK_MAX_KHZ)
			&& frate_ok && lrate_ok;
	end

	// Raster advances only when the sink and the buffer allow
	assign h_act     = (hcnt_ff < `PVT_H_ACTIVE);
	assign v_act     = (vcnt_ff < {1'b0, `PVT_V_ACTIVE});
	// Stop state keeps the raster moving so the frame can finish
	assign adv       = ((st_ff == ST_RUN) || (st_ff == ST_STOP)) && vid_ready
		&& (!(h_act && v_act) || b_valid);
	assign b_ready   = adv && h_act && v_act;
	assign line_end  = (hcnt_ff == `PVT_H_ACTIVE + hb_ff - 12'd1);
	assign frame_end = line_end && (vcnt_ff == {1'b0, `PVT_V_ACTIVE} + vb_ff - 13'd1);

	always @* begin
		nxt_st = st_ff;
		case (st_ff)
			ST_OFF:  if (pg_s2_ff) nxt_st = ST_WAIT;
			ST_WAIT: begin
				if (!pg_s2_ff)
					nxt_st = ST_OFF;
				else if (en_s2_ff && cfg_ok)
					nxt_st = ST_RUN;
			end
			ST_RUN: begin
				if (!pg_s2_ff)
					nxt_st = ST_OFF;
				else if (!en_s2_ff)
					nxt_st = ST_STOP;
			end
			ST_STOP: begin
				if (!pg_s2_ff || (adv && frame_end))
					nxt_st = ST_OFF;
			end
			default: nxt_st = ST_OFF;
		endcase
	end

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_ff       <= ST_OFF;
			hb_ff       <= `PVT_H_BLANK_TYP;
			vb_ff       <= `PVT_V_BLANK_TYP;
			hcnt_ff     <= 12'd0;
			vcnt_ff     <= 13'd0;
			vid_data    <= {PW{1'b0}};
			vid_de      <= 1'b0;
			vid_hs      <= 1'b0;
			vid_vs      <= 1'b0;
			vid_sof     <= 1'b0;
			vid_oe      <= 1'b0;
			running     <= 1'b0;
			cfg_err     <= 1'b0;
			rate_opt    <= 1'b0;
			lane_mbps   <= 16'd0;
			skew_max_ns <= 16'd0;
		end else begin
			st_ff       <= nxt_st;
			cfg_err     <= en_s2_ff && !cfg_ok;
			rate_opt    <= fopt_ok;
			lane_mbps   <= pg_s2_ff ? `PVT_LANE_MBPS : 16'd0;
			skew_max_ns <= `PVT_SKEW_MAX_NS;
			running     <= (nxt_st == ST_RUN) || (nxt_st == ST_STOP);
			vid_oe      <= (nxt_st == ST_RUN) || (nxt_st == ST_STOP);
			if (st_ff == ST_WAIT) begin
				hb_ff   <= cfg_h_blank;
				vb_ff   <= cfg_v_blank;
				hcnt_ff <= 12'd0;
				vcnt_ff <= 13'd0;
			end
			if (nxt_st == ST_OFF || nxt_st == ST_WAIT) begin
				vid_data <= {PW{1'b0}};
				vid_de   <= 1'b0;
				vid_hs   <= 1'b0;
				vid_vs   <= 1'b0;
				vid_sof  <= 1'b0;
			end else if (adv) begin
				vid_data <= b_ready ? b_data : {PW{1'b0}};
				vid_de   <= h_act && v_act;
				vid_hs   <= !h_act;
				vid_vs   <= !v_act;
				vid_sof  <= (hcnt_ff == 12'd0) && (vcnt_ff == 13'd0);
				if (line_end) begin
					hcnt_ff <= 12'd0;
					vcnt_ff <= frame_end ? 13'd0 : vcnt_ff + 13'd1;
				end else begin
					hcnt_ff <= hcnt_ff + 12'd1;
				end
			end else begin
				vid_sof <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// >>> verification/pvt_panel_model.sv
// Panel sink model taking pixels with optional stalls
`timescale 1ns/1ps
`default_nettype none
module pvt_panel_model #(parameter PW = 30) (
	input wire logic      ref_clk,
	input wire logic      nrst,
	input wire logic      slow,
	input wire logic [PW-1:0] vid_data,
	input wire logic      vid_de,
	output logic          vid_ready,
	output logic [11:0]   line_px_ff,
	output logic [PW-1:0] last_px_ff
);
	logic [1:0] phase_ff;
	// Slow mode refuses one edge in four
	assign vid_ready = !(slow && phase_ff == 2'h3);
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			phase_ff <= 2'h0;
			line_px_ff <= 12'h0;
			last_px_ff <= {PW{1'b0}};
		end else begin
			phase_ff <= phase_ff + 2'h1;
			if (vid_de && vid_ready) begin
				line_px_ff <= line_px_ff + 12'h1;
				last_px_ff <= vid_data;
			end else if (!vid_de)
				line_px_ff <= 12'h0;
		end
	end
endmodule
`default_nettype wire

// >>> verification/pvt_source_sva.sv
// Port assertions for the video source
`timescale 1ns/1ps
`default_nettype none
module pvt_source_sva #(parameter PW = 30) (
	input wire logic          ref_clk,
	input wire logic          nrst,
	input wire logic          pwr_good,
	input wire logic [PW-1:0] vid_data,
	input wire logic          vid_de,
	input wire logic          vid_hs,
	input wire logic          vid_vs,
	input wire logic          vid_sof,
	input wire logic          vid_oe,
	input wire logic          vid_ready,
	input wire logic          running,
	input wire logic [15:0]   lane_mbps,
	input wire logic [15:0]   skew_max_ns
);
	logic [11:0] px_cnt_ff;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// Pixels taken by the sink in the current active run
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			px_cnt_ff <= 12'h0;
		else if (!vid_de)
			px_cnt_ff <= 12'h0;
		else if (vid_ready)
			px_cnt_ff <= px_cnt_ff + 12'h1;
	end
	property p_de_hs; vid_de |-> !vid_hs; endproperty
	a_de_hs: assert property (p_de_hs) else $error("pixel in blanking");
	property p_off; !vid_oe |-> vid_data == {PW{1'b0}} && !vid_de; endproperty
	a_off: assert property (p_off) else $error("output while released");
	property p_pwr; !pwr_good [*4] |-> !vid_oe && !running; endproperty
	a_pwr: assert property (p_pwr) else $error("video without supply");
	property p_lane; pwr_good [*5] |-> lane_mbps == 16'ha8c; endproperty
	a_lane: assert property (p_lane) else $error("lane rate wrong");
	property p_skew; running |-> skew_max_ns == 16'hc8; endproperty
	a_skew: assert property (p_skew) else $error("skew limit wrong");
	property p_sof; vid_sof |-> vid_de && !vid_vs; endproperty
	a_sof: assert property (p_sof) else $error("frame start not active");
	property p_stall; running && !vid_ready && pwr_good |=> $stable(vid_data) && $stable(vid_de);
	endproperty
	a_stall: assert property (p_stall) else $error("advance during stall");
	property p_line; $fell(vid_de) && running |-> px_cnt_ff == 12'h780; endproperty
	a_line: assert property (p_line) else $error("active run length wrong");
endmodule
`default_nettype wire

// >>> verification/tb_pvt_source.sv
// Self-checking bench for the video source
`timescale 1ns/1ps
`default_nettype none
module tb_pvt_source;
	localparam PW = 30;
	logic          ref_clk, nrst, pwr_good, video_en, pix_valid, slow;
	logic [11:0]   cfg_h_blank, line_px_ff;
	logic [12:0]   cfg_v_blank;
	logic [31:0]   cfg_pclk_khz;
	logic [PW-1:0] pix_data, vid_data, last_px_ff;
	logic          pix_ready, vid_de, vid_hs, vid_vs, vid_sof, vid_oe, vid_ready;
	logic          running, cfg_err, rate_opt;
	logic [15:0]   lane_mbps, skew_max_ns;
	int            fail_count, num_checks, cyc, i, n;
	logic [11:0]   bad_hb [4] = '{12'h4f, 12'h641, 12'h50, 12'h50};
	logic [12:0]   bad_vb [4] = '{13'h14, 13'h14, 13'h13, 13'h14};
	logic [31:0]   bad_pk [4] = '{32'h43a08, 32'h43a08, 32'h43a08, 32'h1387f};
	pvt_source #(.PW(PW)) dut_u (.ref_clk(ref_clk), .nrst(nrst), .pwr_good(pwr_good),
		.video_en(video_en), .cfg_h_blank(cfg_h_blank), .cfg_v_blank(cfg_v_blank),
		.cfg_pclk_khz(cfg_pclk_khz), .pix_data(pix_data), .pix_valid(pix_valid),
		.pix_ready(pix_ready), .vid_data(vid_data), .vid_de(vid_de), .vid_hs(vid_hs),
		.vid_vs(vid_vs), .vid_sof(vid_sof), .vid_oe(vid_oe), .vid_ready(vid_ready),
		.running(running), .cfg_err(cfg_err), .rate_opt(rate_opt), .lane_mbps(lane_mbps),
		.skew_max_ns(skew_max_ns));
	pvt_panel_model #(.PW(PW)) panel_u (.ref_clk(ref_clk), .nrst(nrst), .slow(slow),
		.vid_data(vid_data), .vid_de(vid_de), .vid_ready(vid_ready),
		.line_px_ff(line_px_ff), .last_px_ff(last_px_ff));
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			tally_and_finish;
		end
	end
	// Pixel counter source, one word per accepted transfer
	always @(posedge ref_clk) if (pix_valid && pix_ready) pix_data <= #1 pix_data + 30'h1;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic t_idle;
		tick(3);
		chk(vid_oe, 1'h0);
		chk(lane_mbps, 16'h0);
		chk(skew_max_ns, 16'hc8);
		chk(pix_ready, 1'h0);
	endtask
	task automatic t_cfg;
		pwr_good = 1'b1;
		video_en = 1'b1;
		for (i = 0; i < 4; i++) begin
			cfg_h_blank = bad_hb[i];
			cfg_v_blank = bad_vb[i];
			cfg_pclk_khz = bad_pk[i];
			tick(6);
			chk(cfg_err, 1'h1);
			chk(running, 1'h0);
		end
		chk(lane_mbps, 16'ha8c);
	endtask
	task automatic t_line;
		slow = 1'b1;
		cfg_h_blank = 12'h50;
		cfg_v_blank = 13'h14;
		cfg_pclk_khz = 32'h43a08;
		for (n = 0; n < 20 && running !== 1'b1; n++) tick(1);
		chk(running, 1'h1);
		chk(rate_opt, 1'h1);
		for (n = 0; n < 20 && vid_sof !== 1'b1; n++) tick(1);
		chk(vid_data, 30'h0);
		for (n = 0; n < 4000 && vid_de !== 1'b0; n++) tick(1);
		chk(line_px_ff, 12'h780);
		chk(last_px_ff, 30'h77f);
		chk(vid_hs, 1'h1);
		n = 0;
		for (i = 0; i < 400 && vid_de !== 1'b1; i++) begin
			if (vid_hs && vid_ready) n++;
			tick(1);
		end
		chk(n, 32'h50);
		chk(vid_vs, 1'h0);
		chk(vid_data, 30'h780);
	endtask
	task automatic t_off;
		video_en = 1'b0;
		for (n = 0; n < 3000 && vid_hs !== 1'b1; n++) tick(1);
		for (n = 0; n < 3000 && vid_de !== 1'b1; n++) tick(1);
		chk(vid_de, 1'h1);
		chk(running, 1'h1);
		pwr_good = 1'b0;
		tick(3);
		chk(vid_oe, 1'h0);
		chk(vid_data, 30'h0);
		chk(running, 1'h0);
		tick(2);
		chk(lane_mbps, 16'h0);
	endtask
	initial begin
		{nrst, pwr_good, video_en, pix_valid, slow} = 5'h0;
		{cfg_h_blank, cfg_v_blank, cfg_pclk_khz, pix_data} = '0;
		{fail_count, num_checks, cyc} = '0;
		repeat (6) @(posedge ref_clk);
		#1;
		nrst = 1'b1;
		pix_valid = 1'b1;
		t_idle;
		t_cfg;
		t_line;
		t_off;
		tally_and_finish;
	end
endmodule
bind pvt_source pvt_source_sva #(.PW(PW)) sva_u (.ref_clk(ref_clk), .nrst(nrst),
	.pwr_good(pwr_good), .vid_data(vid_data), .vid_de(vid_de), .vid_hs(vid_hs),
	.vid_vs(vid_vs), .vid_sof(vid_sof), .vid_oe(vid_oe), .vid_ready(vid_ready),
	.running(running), .lane_mbps(lane_mbps), .skew_max_ns(skew_max_ns));
`default_nettype wire
